// ### inc/dlc_cfg.svh
// Constants for the divide, loop and extended call execution block
`ifndef DLC_CFG_SVH
`define DLC_CFG_SVH
`define DLC_OP_DIVB     3'h1
`define DLC_OP_DIVW     3'h2
`define DLC_OP_DIVAB    3'h3
`define DLC_OP_DECREMENT_BRANCH_NONZERO_OP     3'h4
`define DLC_OP_EXTENDED_CALL_OP    3'h5
`define DLC_OP_DECW     3'h6
`define DLC_OP_DECD     3'h7
`define DLC_CALL_ADV    24'h000004
`define DLC_WORD_STEP   5'h02
`define DLC_SP_STEP     8'h01
`define DLC_BYTE_ONE    8'h01
`define DLC_PUSH_BYTES  2'h3
`endif

// ### inc/dlc_pkg.sv
// Types for the divide, loop and extended call execution block
package dlc_pkg;
    typedef enum logic [2:0] {
        DLC_IDLE  = 3'b000,
        DLC_DIV   = 3'b001,
        DLC_WB    = 3'b010,
        DLC_PUSH  = 3'b011,
        DLC_DONE  = 3'b100
    } dlc_state_t;

    typedef struct packed {
        logic [2:0]  op;
        logic [4:0]  dest_idx;
        logic [15:0] dividend;
        logic [15:0] divisor;
        logic [7:0]  count_val;
        logic [7:0]  rel;
        logic [23:0] pc;
        logic [23:0] target;
        logic [7:0]  sp;
        logic [31:0] wide_val;
        logic [2:0]  short_val;
    } dlc_req_t;

    typedef struct packed {
        logic carry_flag;
        logic overflow_flag;
        logic neg_flag;
        logic zero_flag;
        logic carry_we;
        logic overflow_we;
        logic nz_we;
    } dlc_flags_t;
endpackage : dlc_pkg

// ### rtl/dlc_divider.sv
// Iterative restoring unsigned divider, one quotient bit per cycle
`timescale 1ns/100ps
module dlc_divider #(
    parameter int W = 16
) (
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic         start,
    input  wire logic [W-1:0] dividend,
    input  wire logic [W-1:0] divisor,
    input  wire logic [4:0]   nbits,
    output logic              done,
    output logic [W-1:0]      quotient,
    output logic [W-1:0]      remainder
);
    typedef struct packed {
        logic [W-1:0] q;
        logic [W-1:0] r;
        logic [4:0]   cnt;
        logic         busy;
        logic         done;
    } dlc_div_st_t;

    dlc_div_st_t s_q;
    dlc_div_st_t s_d;
    logic [W:0]  trial;

    always_comb begin
        s_d   = s_q;
        trial = '0;
        s_d.done = 1'b0;
        if (start) begin
            s_d.q    = dividend << (5'(W) - nbits);
            s_d.r    = '0;
            s_d.cnt  = nbits;
            s_d.busy = 1'b1;
        end else if (s_q.busy) begin
            trial = {s_q.r, s_q.q[W-1]} - {1'b0, divisor};
            if (!trial[W]) begin
                s_d.r = trial[W-1:0];
                s_d.q = {s_q.q[W-2:0], 1'b1};
            end else begin
                s_d.r = {s_q.r[W-2:0], s_q.q[W-1]};
                s_d.q = {s_q.q[W-2:0], 1'b0};
            end
            s_d.cnt = s_q.cnt - 5'h01;
            if (s_q.cnt == 5'h01) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done      = s_q.done;
    assign quotient  = s_q.q;
    assign remainder = s_q.r;
endmodule : dlc_divider

// ### rtl/dlc_exec.sv
// Divide, decrement-and-branch and extended call execution unit
// How it works
// - Register divide unsigned; nonzero divisor clears carry and overflow
// - Even byte dest: remainder there, quotient above
// - Odd byte dest: quotient there, remainder below
// - Word dest multiple of four: remainder, quotient above
// - Word dest 2 mod 4: quotient, remainder below
// - Divide clears carry; N, Z from quotient
// - Zero divisor: carry clear, overflow set
// - Accumulator divide: quotient to A, remainder aux
// - Zero aux divisor: carry clear, overflow set
// - Decrement wraps; branch when result nonzero
// - Branch target: next PC plus signed displacement
// - Counted byte: general register or direct location
// - Port operand counted from output latch value
// - Return address is PC plus four
// - Push three bytes high first, pre-increment SP
// - PC loaded from 24-bit target bytes
`timescale 1ns/100ps
`include "dlc_cfg.svh"
module dlc_exec (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic              req_valid,
    input  wire dlc_pkg::dlc_req_t req,
    input  wire logic              cnt_is_port,
    input  wire logic [7:0]        port_latch_val,
    output logic                   busy,
    output logic                   done,
    output logic                   wr_en,
    output logic [4:0]             wr_idx,
    output logic [15:0]            wr_data,
    output logic                   wr_word,
    output logic                   wr2_en,
    output logic [4:0]             wr2_idx,
    output logic [15:0]            wr2_data,
    output logic                   acc_we,
    output logic [7:0]             acc_data,
    output logic                   aux_we,
    output logic [7:0]             aux_data,
    output logic                   cnt_we,
    output logic [7:0]             cnt_data,
    output logic                   wide_we,
    output logic [31:0]            wide_data,
    output logic                   stk_we,
    output logic [7:0]             stk_addr,
    output logic [7:0]             stk_data,
    output logic                   sp_we,
    output logic [7:0]             sp_data,
    output logic                   pc_we,
    output logic [23:0]            pc_data,
    output dlc_pkg::dlc_flags_t    flags
);
    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        dlc_pkg::dlc_state_t st;
        dlc_pkg::dlc_req_t   r;
        logic [1:0]          push_n;
        logic [23:0]         ret;
        logic                busy;
        logic                done;
        logic                wr_en;
        logic [4:0]          wr_idx;
        logic [15:0]         wr_data;
        logic                wr_word;
        logic                wr2_en;
        logic [4:0]          wr2_idx;
        logic [15:0]         wr2_data;
        logic                acc_we;
        logic [7:0]          acc_data;
        logic                aux_we;
        logic [7:0]          aux_data;
        logic                cnt_we;
        logic [7:0]          cnt_data;
        logic                wide_we;
        logic [31:0]         wide_data;
        logic                stk_we;
        logic [7:0]          stk_addr;
        logic [7:0]          stk_data;
        logic                sp_we;
        logic [7:0]          sp_data;
        logic                pc_we;
        logic [23:0]         pc_data;
        dlc_pkg::dlc_flags_t flags;
    } dlc_exec_st_t;

    dlc_exec_st_t s_q;
    dlc_exec_st_t s_d;

    logic        div_start;
    logic        div_done;
    logic [15:0] div_q;
    logic [15:0] div_r;
    logic [4:0]  div_bits;
    logic [7:0]  cnt_src;
    logic [7:0]  cnt_dec;
    logic [23:0] ret_addr;

    // ==========================================================
    // Divider
    // ==========================================================
    assign div_bits = (s_q.r.op == `DLC_OP_DIVW) ? 5'h10 : 5'h08;

    dlc_divider #(.W(16)) u_div (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .start     (div_start),
        .dividend  (s_q.r.dividend),
        .divisor   (s_q.r.divisor),
        .nbits     (div_bits),
        .done      (div_done),
        .quotient  (div_q),
        .remainder (div_r)
    );

    // ==========================================================
    // Decrement-and-branch and call arithmetic
    // ==========================================================
    // A port operand counts from its output latch, never the pins
    assign cnt_src  = cnt_is_port ? port_latch_val : req.count_val;
    assign cnt_dec  = cnt_src - `DLC_BYTE_ONE;
    assign ret_addr = s_q.r.pc + `DLC_CALL_ADV;

    // ==========================================================
    // Sequencer
    // ==========================================================
    always_comb begin
        s_d           = s_q;
        div_start     = 1'b0;
        s_d.done      = 1'b0;
        s_d.wr_en     = 1'b0;
        s_d.wr2_en    = 1'b0;
        s_d.acc_we    = 1'b0;
        s_d.aux_we    = 1'b0;
        s_d.cnt_we    = 1'b0;
        s_d.wide_we   = 1'b0;
        s_d.stk_we    = 1'b0;
        s_d.sp_we     = 1'b0;
        s_d.pc_we     = 1'b0;
        s_d.flags.carry_we    = 1'b0;
        s_d.flags.overflow_we = 1'b0;
        s_d.flags.nz_we       = 1'b0;
        case (s_q.st)
            dlc_pkg::DLC_IDLE: begin
                if (req_valid) begin
                    s_d.r    = req;
                    s_d.busy = 1'b1;
                    case (req.op)
                        `DLC_OP_DIVB, `DLC_OP_DIVW, `DLC_OP_DIVAB: begin
                            s_d.st = dlc_pkg::DLC_DIV;
                        end
                        `DLC_OP_DECREMENT_BRANCH_NONZERO_OP: begin
                            s_d.cnt_we   = 1'b1;
                            s_d.cnt_data = cnt_dec;
                            s_d.flags.nz_we     = 1'b1;
                            s_d.flags.neg_flag  = cnt_dec[7];
                            s_d.flags.zero_flag = (cnt_dec == 8'h00);
                            if (cnt_dec != 8'h00) begin
                                s_d.pc_we   = 1'b1;
                                s_d.pc_data = req.pc +
                                    {{16{req.rel[7]}}, req.rel};
                            end
                            s_d.st = dlc_pkg::DLC_DONE;
                        end
                        `DLC_OP_EXTENDED_CALL_OP: begin
                            s_d.push_n = `DLC_PUSH_BYTES;
                            s_d.st     = dlc_pkg::DLC_PUSH;
                        end
                        `DLC_OP_DECW, `DLC_OP_DECD: begin
                            s_d.wide_we   = 1'b1;
                            s_d.wide_data = req.wide_val -
                                {29'h0, req.short_val};
                            if (req.op == `DLC_OP_DECW) begin
                                s_d.wide_data[31:16] = req.wide_val[31:16];
                            end
                            s_d.st = dlc_pkg::DLC_DONE;
                        end
                        default: begin
                            s_d.st = dlc_pkg::DLC_DONE;
                        end
                    endcase
                end
            end
            dlc_pkg::DLC_DIV: begin
                div_start = 1'b1;
                s_d.st    = dlc_pkg::DLC_WB;
            end
            dlc_pkg::DLC_WB: begin
                if (div_done) begin
                    // Carry always cleared; overflow marks zero divisor
                    s_d.flags.carry_we      = 1'b1;
                    s_d.flags.overflow_we   = 1'b1;
                    s_d.flags.carry_flag    = 1'b0;
                    s_d.flags.overflow_flag =
                        (s_q.r.divisor == 16'h0000);
                    s_d.flags.nz_we = 1'b1;
                    s_d.wr_en  = (s_q.r.op != `DLC_OP_DIVAB);
                    s_d.wr2_en = (s_q.r.op != `DLC_OP_DIVAB);
                    s_d.wr_word = (s_q.r.op == `DLC_OP_DIVW);
                    if (s_q.r.op == `DLC_OP_DIVW) begin
                        s_d.flags.neg_flag  = div_q[15];
                        s_d.flags.zero_flag = (div_q == 16'h0000);
                        if (!s_q.r.dest_idx[1]) begin
                            s_d.wr_idx   = s_q.r.dest_idx;
                            s_d.wr_data  = div_r;
                            s_d.wr2_idx  = s_q.r.dest_idx + `DLC_WORD_STEP;
                            s_d.wr2_data = div_q;
                        end else begin
                            s_d.wr_idx   = s_q.r.dest_idx;
                            s_d.wr_data  = div_q;
                            s_d.wr2_idx  = s_q.r.dest_idx - `DLC_WORD_STEP;
                            s_d.wr2_data = div_r;
                        end
                    end else begin
                        s_d.flags.neg_flag  = div_q[7];
                        s_d.flags.zero_flag = (div_q[7:0] == 8'h00);
                        if (s_q.r.op == `DLC_OP_DIVAB) begin
                            s_d.acc_we   = 1'b1;
                            s_d.acc_data = div_q[7:0];
                            s_d.aux_we   = 1'b1;
                            s_d.aux_data = div_r[7:0];
                        end else if (!s_q.r.dest_idx[0]) begin
                            s_d.wr_idx   = s_q.r.dest_idx;
                            s_d.wr_data  = {8'h00, div_r[7:0]};
                            s_d.wr2_idx  = s_q.r.dest_idx | 5'h01;
                            s_d.wr2_data = {8'h00, div_q[7:0]};
                        end else begin
                            s_d.wr_idx   = s_q.r.dest_idx;
                            s_d.wr_data  = {8'h00, div_q[7:0]};
                            s_d.wr2_idx  = s_q.r.dest_idx & 5'h1e;
                            s_d.wr2_data = {8'h00, div_r[7:0]};
                        end
                    end
                    s_d.st = dlc_pkg::DLC_DONE;
                end
            end
            dlc_pkg::DLC_PUSH: begin
                // Pre-increment then write; high byte leaves first
                s_d.r.sp     = s_q.r.sp + `DLC_SP_STEP;
                s_d.stk_we   = 1'b1;
                s_d.stk_addr = s_q.r.sp + `DLC_SP_STEP;
                s_d.sp_we    = 1'b1;
                s_d.sp_data  = s_q.r.sp + `DLC_SP_STEP;
                case (s_q.push_n)
                    2'h3: s_d.stk_data = ret_addr[23:16];
                    2'h2: s_d.stk_data = ret_addr[15:8];
                    default: s_d.stk_data = ret_addr[7:0];
                endcase
                s_d.push_n = s_q.push_n - 2'h1;
                if (s_q.push_n == 2'h1) begin
                    s_d.pc_we   = 1'b1;
                    s_d.pc_data = s_q.r.target;
                    s_d.st      = dlc_pkg::DLC_DONE;
                end
                // Flag write enables stay low throughout the call
                s_d.flags.nz_we = 1'b0;
            end
            dlc_pkg::DLC_DONE: begin
                s_d.done = 1'b1;
                s_d.busy = 1'b0;
                s_d.st   = dlc_pkg::DLC_IDLE;
            end
            default: begin
                s_d.st   = dlc_pkg::DLC_IDLE;
                s_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q    <= '0;
            s_q.st <= dlc_pkg::DLC_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign busy      = s_q.busy;
    assign done      = s_q.done;
    assign wr_en     = s_q.wr_en;
    assign wr_idx    = s_q.wr_idx;
    assign wr_data   = s_q.wr_data;
    assign wr_word   = s_q.wr_word;
    assign wr2_en    = s_q.wr2_en;
    assign wr2_idx   = s_q.wr2_idx;
    assign wr2_data  = s_q.wr2_data;
    assign acc_we    = s_q.acc_we;
    assign acc_data  = s_q.acc_data;
    assign aux_we    = s_q.aux_we;
    assign aux_data  = s_q.aux_data;
    assign cnt_we    = s_q.cnt_we;
    assign cnt_data  = s_q.cnt_data;
    assign wide_we   = s_q.wide_we;
    assign wide_data = s_q.wide_data;
    assign stk_we    = s_q.stk_we;
    assign stk_addr  = s_q.stk_addr;
    assign stk_data  = s_q.stk_data;
    assign sp_we     = s_q.sp_we;
    assign sp_data   = s_q.sp_data;
    assign pc_we     = s_q.pc_we;
    assign pc_data   = s_q.pc_data;
    assign flags     = s_q.flags;
endmodule : dlc_exec

// ### tb/dlc_exec_assertions.sv
// Concurrent checks on the execution unit's output timing and values
`timescale 1ns/100ps
module dlc_exec_assertions (
    input wire logic                sys_clk,
    input wire logic                resetn,
    input wire logic                busy,
    input wire logic                done,
    input wire logic                wr_en,
    input wire logic [4:0]          wr_idx,
    input wire logic                wr_word,
    input wire logic                wr2_en,
    input wire logic [4:0]          wr2_idx,
    input wire logic                acc_we,
    input wire logic                cnt_we,
    input wire logic [7:0]          cnt_data,
    input wire logic                stk_we,
    input wire logic [7:0]          stk_addr,
    input wire logic                pc_we,
    input wire dlc_pkg::dlc_flags_t flags
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // ==========================================
    // Divide results
    AST_DIV_FLAGS: assert property (wr_en |-> flags.carry_we &&
        !flags.carry_flag && flags.overflow_we)
        else $error("divide carry or overflow not written");
    AST_WR_PAIR: assert property (wr_en |-> wr2_en ##1 done)
        else $error("divide writes not paired or done late");
    AST_BYTE_IDX: assert property (wr_en && !wr_word |->
        (wr_idx ^ wr2_idx) == 5'h01)
        else $error("byte divide result indices not adjacent");
    AST_WORD_IDX: assert property (wr_en && wr_word |->
        (wr_idx ^ wr2_idx) == 5'h02)
        else $error("word divide result indices not two apart");
    AST_ACC_FLAGS: assert property (acc_we |-> flags.carry_we &&
        !flags.carry_flag ##1 done)
        else $error("accumulator divide flags or done wrong");
    AST_BUSY_BOUND: assert property ($rose(busy) |->
        ##[1:20] $fell(busy))
        else $error("operation did not finish in time");

    // ==========================================
    // Decrement and branch
    AST_CNT_NZ: assert property (cnt_we |-> flags.nz_we &&
        flags.zero_flag == (cnt_data == 8'h00) &&
        flags.neg_flag == cnt_data[7])
        else $error("count flags do not follow result");
    AST_NO_BRANCH: assert property (cnt_we && cnt_data == 8'h00 |->
        !pc_we)
        else $error("branch taken on zero count");

    // ==========================================
    // Extended call
    AST_PUSH_RUN: assert property ($rose(stk_we) |->
        stk_we[*3] ##1 !stk_we)
        else $error("call did not push exactly three bytes");
    AST_PUSH_ADDR: assert property (stk_we && $past(stk_we) |->
        stk_addr == $past(stk_addr) + 8'h01)
        else $error("stack address not incremented");
    AST_PUSH_PC: assert property ($rose(stk_we) |->
        !pc_we ##1 !pc_we ##1 pc_we)
        else $error("program counter not loaded with last push");
    AST_CALL_FLAGS: assert property (stk_we |-> !flags.carry_we &&
        !flags.overflow_we && !flags.nz_we)
        else $error("call touched flags");
endmodule : dlc_exec_assertions

bind dlc_exec dlc_exec_assertions u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .busy(busy), .done(done),
    .wr_en(wr_en), .wr_idx(wr_idx), .wr_word(wr_word), .wr2_en(wr2_en),
    .wr2_idx(wr2_idx), .acc_we(acc_we), .cnt_we(cnt_we),
    .cnt_data(cnt_data), .stk_we(stk_we), .stk_addr(stk_addr),
    .pc_we(pc_we), .flags(flags)
);

// ### tb/dlc_exec_tb.sv
// Randomised self-checking bench for the execution unit
`timescale 1ns/100ps
`include "dlc_cfg.svh"
module dlc_exec_tb;
    logic                sys_clk, resetn, req_valid, cnt_is_port;
    logic [7:0]          port_latch_val;
    dlc_pkg::dlc_req_t   req;
    logic                busy, done, wr_en, wr_word, wr2_en, acc_we, aux_we;
    logic                cnt_we, wide_we, stk_we, sp_we, pc_we;
    logic [4:0]          wr_idx, wr2_idx;
    logic [15:0]         wr_data, wr2_data;
    logic [7:0]          acc_data, aux_data, cnt_data, stk_addr, stk_data;
    logic [7:0]          sp_data;
    logic [31:0]         wide_data;
    logic [23:0]         pc_data;
    dlc_pkg::dlc_flags_t flags, fl;
    int                  seed = 32'hf939;
    int                  fail_count = 0;
    int                  num_checks = 0;
    int                  npush;
    logic [15:0]         w_dat [2];
    logic [4:0]          w_idx [2];
    logic [7:0]          sa [3], sd [3], c_acc, c_aux, c_cnt, c_sp;
    logic [31:0]         c_wide;
    logic [23:0]         c_pc;
    logic                pc_seen, fen;

    dlc_exec u_dlc_exec (
        .sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid),
        .req(req), .cnt_is_port(cnt_is_port),
        .port_latch_val(port_latch_val), .busy(busy), .done(done),
        .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
        .wr_word(wr_word), .wr2_en(wr2_en), .wr2_idx(wr2_idx),
        .wr2_data(wr2_data), .acc_we(acc_we), .acc_data(acc_data),
        .aux_we(aux_we), .aux_data(aux_data), .cnt_we(cnt_we),
        .cnt_data(cnt_data), .wide_we(wide_we), .wide_data(wide_data),
        .stk_we(stk_we), .stk_addr(stk_addr), .stk_data(stk_data),
        .sp_we(sp_we), .sp_data(sp_data), .pc_we(pc_we),
        .pc_data(pc_data), .flags(flags)
    );

    // ==========================================
    // Checking helpers
    task automatic final_report();
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    function automatic logic [15:0] at(input logic [4:0] idx, input bit b);
        logic [15:0] d;
        d = (w_idx[0] === idx) ? w_dat[0] :
            (w_idx[1] === idx) ? w_dat[1] : 16'hxxxx;
        return b ? {8'h00, d[7:0]} : d;
    endfunction : at

    // ==========================================
    // One request, outputs captured until done
    task automatic run(input dlc_pkg::dlc_req_t r, input bit hold);
        int i;
        @(posedge sys_clk);
        #2;
        req_valid = 1'b1;
        req = r;
        npush = 0;
        pc_seen = 1'b0;
        fen = 1'b0;
        fl = '0;
        w_idx[0] = 5'hxx;
        w_idx[1] = 5'hxx;
        for (i = 0; i < 40; i++) begin
            @(posedge sys_clk);
            #1;
            if (wr_en) begin
                w_idx = '{wr_idx, wr2_idx};
                w_dat = '{wr_data, wr2_data};
            end
            if (acc_we) c_acc = acc_data;
            if (aux_we) c_aux = aux_data;
            if (cnt_we) c_cnt = cnt_data;
            if (wide_we) c_wide = wide_data;
            if (sp_we) c_sp = sp_data;
            if (pc_we) begin
                pc_seen = 1'b1;
                c_pc = pc_data;
            end
            if (stk_we && npush < 3) begin
                sa[npush] = stk_addr;
                sd[npush] = stk_data;
                npush++;
            end
            if (flags.carry_we || flags.overflow_we || flags.nz_we) begin
                fen = 1'b1;
                fl = flags;
            end
            // One-cycle ops write on the accept edge itself
            if (i == 0) begin
                #1;
                req_valid = hold;
                req.dividend = ~r.dividend;
                req.dest_idx = ~r.dest_idx;
            end
            if (done) break;
        end
        #1;
        req_valid = 1'b0;
        if (i == 40) begin
            chk("done", 0, 1);
            final_report();
        end
    endtask : run

    // ==========================================
    // Random requests of one kind, with corner cases first
    task automatic scen(input logic [2:0] op, input int n);
        dlc_pkg::dlc_req_t r;
        logic [15:0] a, b, q, m;
        logic [4:0]  d, qi, ri;
        logic [7:0]  orig, res;
        logic [23:0] ret;
        logic [31:0] w;
        bit          bw;
        for (int k = 0; k < n; k++) begin
            r = '0;
            r.op = op;
            bw = (op != `DLC_OP_DIVW);
            a = bw ? {8'h00, 8'($random(seed))} : 16'($random(seed));
            b = bw ? {8'h00, 8'($random(seed))} : 16'($random(seed));
            if (k == 0) a = bw ? 16'h00fb : 16'hffff;
            if (k == 0) b = bw ? 16'h0012 : 16'h0001;
            if (k == 1 || ($random(seed) & 7) == 0) b = 16'h0000;
            d = bw ? 5'($random(seed) & 15) : 5'(($random(seed) & 15) << 1);
            r.dest_idx = d;
            r.dividend = a;
            r.divisor = b;
            r.count_val = (k < 2) ? 8'(k) : 8'($random(seed));
            r.rel = 8'($random(seed));
            r.pc = 24'($random(seed));
            r.sp = 8'($random(seed));
            r.target = 24'($random(seed));
            r.wide_val = (k == 0) ? 32'h0000_0000 : $random(seed);
            r.short_val = 3'h1 << ((32'($random(seed)) & 32'hff) % 3);
            if (op == `DLC_OP_DECW || op == `DLC_OP_DECD) r.pc = 24'hfffffc;
            cnt_is_port = (k >= 2) && $random(seed);
            port_latch_val = (k < 2) ? 8'(k) : 8'($random(seed));
            run(r, (op <= `DLC_OP_DIVAB) && $random(seed));
            q = (b == 0) ? 16'h0000 : a / b;
            m = (b == 0) ? 16'h0000 : a % b;
            qi = bw ? (d[0] ? d : d + 5'h01) : (d[1] ? d : d + 5'h02);
            ri = bw ? (d[0] ? d - 5'h01 : d) : (d[1] ? d - 5'h02 : d);
            orig = cnt_is_port ? port_latch_val : r.count_val;
            res = orig - 8'h01;
            ret = r.pc + 24'h000004;
            w = r.wide_val;
            if (op <= `DLC_OP_DIVAB) begin
                chk("div_flag_en", fen, 1);
                chk("carry", fl.carry_flag, 0);
                chk("overflow", fl.overflow_flag, b == 0);
            end
            if (op <= `DLC_OP_DIVW && b != 0) begin
                chk("quotient", at(qi, bw), q);
                chk("remainder", at(ri, bw), m);
                chk("neg", fl.neg_flag, bw ? q[7] : q[15]);
                chk("zero", fl.zero_flag, q == 0);
            end
            if (op == `DLC_OP_DIVAB && b != 0) begin
                chk("acc", c_acc, q);
                chk("aux", c_aux, m);
            end
            if (op == `DLC_OP_DIVAB && b == 0)
                chk("aux_zero_ovf", fl.overflow_flag, 1);
            if (op == `DLC_OP_DECREMENT_BRANCH_NONZERO_OP) begin
                chk("count", c_cnt, res);
                chk("taken", pc_seen, res != 0);
                if (res != 0)
                    chk("target", c_pc,
                        24'(r.pc + {{16{r.rel[7]}}, r.rel}));
                chk("zero", fl.zero_flag, res == 0);
            end
            if (op == `DLC_OP_EXTENDED_CALL_OP) begin
                chk("pushes", npush, 3);
                for (int j = 0; j < 3; j++) begin
                    chk("push_addr", sa[j], 8'(r.sp + 8'(j + 1)));
                    chk("push_data", sd[j], ret[23 - 8 * j -: 8]);
                end
                chk("sp", c_sp, 8'(r.sp + 8'h03));
                chk("pc", c_pc, r.target);
                chk("call_flags", fen, 0);
            end
            if (op == `DLC_OP_DECW)
                chk("decw", c_wide,
                    {w[31:16], w[15:0] - 16'(r.short_val)});
            if (op == `DLC_OP_DECD)
                chk("decd", c_wide, w - 32'(r.short_val));
        end
    endtask : scen

    // ==========================================
    // Clock, reset and main sequence
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        resetn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        cnt_is_port = 1'b0;
        port_latch_val = 8'h00;
        repeat (10) @(posedge sys_clk);
        #2;
        resetn = 1'b1;
        for (int o = 1; o < 8; o++) scen(3'(o), 30);
        @(posedge sys_clk);
        #2;
        resetn = 1'b0;
        repeat (10) @(posedge sys_clk);
        #2;
        resetn = 1'b1;
        scen(`DLC_OP_EXTENDED_CALL_OP, 4);
        scen(`DLC_OP_DIVB, 4);
        final_report();
    end
endmodule : dlc_exec_tb
